// ===== compact_timer_pkg.sv
// Purpose: constants shared by the compact timer register block
// Assumes: byte-wide registers on a small local address space
// Notes:   offsets are word indices on the plain register port
package compact_timer_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_TIMER_CONTROL = 4'h0;
  localparam logic [3:0] OFS_MODE_CONTROL  = 4'h1;
  localparam logic [3:0] OFS_COUNT_LOW     = 4'h2;
  localparam logic [3:0] OFS_COUNT_HIGH    = 4'h3;
  localparam logic [3:0] OFS_MATCH_A_LOW   = 4'h4;
  localparam logic [3:0] OFS_MATCH_A_HIGH  = 4'h5;
  localparam logic [3:0] OFS_MATCH_P       = 4'h6;
  localparam logic [3:0] OFS_MATCH_FLAGS   = 4'h7;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int POS_PAUSE      = 7;
  localparam int POS_TIMER_ON   = 3;
  localparam int POS_MODE_HI    = 7;
  localparam int POS_MODE_LO    = 6;
  localparam int POS_PINF_HI    = 5;
  localparam int POS_PINF_LO    = 4;
  localparam int POS_LEVEL      = 3;
  localparam int POS_INVERT     = 2;
  localparam int POS_SWAP       = 1;
  localparam int POS_CLEAR_SRC  = 0;
  localparam int POS_FLAG_A     = 0;
  localparam int POS_FLAG_P     = 1;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [1:0]  MODE_COMPARE = 2'b00;
  localparam logic [1:0]  MODE_PWM     = 2'b10;
  localparam logic [1:0]  MODE_TIMER   = 2'b11;
  localparam logic [1:0]  PINF_HOLD    = 2'b00;
  localparam logic [1:0]  PINF_LOW     = 2'b01;
  localparam logic [1:0]  PINF_HIGH    = 2'b10;
  localparam logic [1:0]  PINF_TOGGLE  = 2'b11;
  localparam logic [1:0]  PWMF_OFF     = 2'b00;
  localparam logic [1:0]  PWMF_ON      = 2'b01;
  localparam logic [1:0]  PWMF_WAVE    = 2'b10;

endpackage : compact_timer_pkg

// ===== compact_timer.sv
// Purpose: 16-bit count-up compact timer with compare and pwm output
// Assumes: timer_tick is a one-cycle pulse per selected timer clock edge
// Notes:   low bytes pass through one shared 8-bit buffer
//
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - mode field picks compare 00, pwm 10, timer 11; 01 undefined.
// - timer mode leaves output pin undriven; pin function unused.
// - compare match A holds, drives low, drives high or toggles output.
// - pwm pin function forces inactive, forces active or passes waveform.
// - requested level equal to initial level shows no pin change.
// - timer-on rising edge returns output to its initial level.
// - level bit is initial level in compare, active level in pwm.
// - invert bit inverts the pin in compare and pwm modes.
// - swap bit exchanges period and duty roles of P and A.
// - clear source 1 clears on match A; 0 on match P or overflow.
// - overflow clearing only when P value is zero and P is selected.
// - pwm mode ignores clear source bit.
// - counter readable as low and high read-only bytes, reset zero.
// - 16-bit A value read-write in two bytes, compared to all bits.
// - 8-bit P value compared with counter bits 15 to 8.
// - P value n gives 256n clocks; zero gives 65536 by overflow.
// - low bytes go through shared buffer moved on high byte access.
// - timer-on rise zeroes counter; fall stops and keeps count.
// - compare mode pin changes on match A or timer-on rise, never on match P.
module compact_timer
  import compact_timer_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       timer_tick,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output var  logic [7:0] reg_rdata,
  output var  logic       timer_output_pin,
  output var  logic       timer_output_en
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic        timer_on_r;
  logic        pause_r;
  logic [7:0]  mode_control_r;
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] compare_a_r;
  logic [7:0]  compare_p_r;
  logic [7:0]  low_buf_r;
  logic        match_a_flag_r;
  logic        match_p_flag_r;
  logic        cmp_out_r;
  logic        cmp_out_nxt;
  logic [7:0]  rdata_r;
  logic [7:0]  rdata_nxt;
  logic        pin_r;
  logic        pin_nxt;
  logic        pin_en_r;

  // ----------------------------------------------------------------
  // field views
  // ----------------------------------------------------------------
  wire [1:0] mode_select         = mode_control_r[POS_MODE_HI:POS_MODE_LO];
  wire [1:0] pin_function_select = mode_control_r[POS_PINF_HI:POS_PINF_LO];
  wire       output_level_bit    = mode_control_r[POS_LEVEL];
  wire       output_invert_bit   = mode_control_r[POS_INVERT];
  wire       duty_period_swap    = mode_control_r[POS_SWAP];
  wire       clear_source_select = mode_control_r[POS_CLEAR_SRC];

  // mode decode; code 01 counts like compare mode with the pin released
  wire is_pwm   = (mode_select == MODE_PWM);
  wire is_cmp   = (mode_select == MODE_COMPARE);
  wire pin_used = is_pwm | is_cmp;

  // ----------------------------------------------------------------
  // register port decode
  // ----------------------------------------------------------------
  wire wr_ctrl  = reg_write & (reg_addr == OFS_TIMER_CONTROL);
  wire wr_mode  = reg_write & (reg_addr == OFS_MODE_CONTROL);
  wire wr_a_lo  = reg_write & (reg_addr == OFS_MATCH_A_LOW);
  wire wr_a_hi  = reg_write & (reg_addr == OFS_MATCH_A_HIGH);
  wire wr_p     = reg_write & (reg_addr == OFS_MATCH_P);
  wire wr_flags = reg_write & (reg_addr == OFS_MATCH_FLAGS);
  wire rd_c_hi  = reg_read & (reg_addr == OFS_COUNT_HIGH);
  wire rd_a_hi  = reg_read & (reg_addr == OFS_MATCH_A_HIGH);

  // timer-on edges seen at the control write
  wire on_rise = wr_ctrl & reg_wdata[POS_TIMER_ON] & ~timer_on_r;
  wire running = timer_on_r & ~pause_r;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  // match is judged on the value the counter is about to take, so a
  // clear lands after exactly n counts
  wire [15:0] count_inc = count_r + 16'h0001;
  wire        step      = running & timer_tick & ~on_rise;

  // P is compared with the high byte and needs a zero low byte; zero matches the wrap to 0000
  wire p_eq  = (count_inc[15:8] == compare_p_r) &
               (count_inc[7:0] == 8'h00);
  wire p_hit = step & p_eq;
  // A zero A value wraps without a match
  wire a_hit = step & (count_inc == compare_a_r) &
               (compare_a_r != RST_WORD);

  // counter clear source
  wire clr_by_a = is_pwm ? duty_period_swap
                         : clear_source_select;
  wire clr_hit  = clr_by_a ? a_hit : p_hit;
  wire p_flags  = is_pwm | ~clear_source_select;

  // ----------------------------------------------------------------
  // counter next value
  // ----------------------------------------------------------------
  always_comb begin
    if (on_rise) begin
      count_nxt = RST_WORD;
    end else if (clr_hit) begin
      count_nxt = RST_WORD;
    end else if (step) begin
      count_nxt = count_inc;
    end else begin
      count_nxt = count_r;
    end
  end

  // ----------------------------------------------------------------
  // compare output state
  // ----------------------------------------------------------------
  // match A or a timer-on rise moves it; setting a level it already has is no change
  always_comb begin
    cmp_out_nxt = cmp_out_r;
    if (on_rise) begin
      cmp_out_nxt = mode_control_r[POS_LEVEL];
    end else if (a_hit & is_cmp) begin
      case (pin_function_select)
        PINF_LOW:    cmp_out_nxt = 1'b0;
        PINF_HIGH:   cmp_out_nxt = 1'b1;
        PINF_TOGGLE: cmp_out_nxt = ~cmp_out_r;
        default:     cmp_out_nxt = cmp_out_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pwm waveform
  // ----------------------------------------------------------------
  // duty from A unless swapped; a P duty of zero means 65536
  wire [16:0] duty_p  = (compare_p_r == RST_BYTE) ? 17'h1_0000
                        : {1'b0, compare_p_r, 8'h00};
  wire [16:0] duty    = duty_period_swap ? duty_p
                        : {1'b0, compare_a_r};
  wire        pwm_act = ({1'b0, count_r} < duty);
  wire        pwm_lvl = pwm_act ? output_level_bit
                        : ~output_level_bit;

  // pin function in pwm mode; undefined code held inactive
  wire pwm_pin = (pin_function_select == PWMF_WAVE) ? pwm_lvl
               : (pin_function_select == PWMF_ON) ? output_level_bit
               : ~output_level_bit;

  // selected level, inverted when asked, dropped in timer mode
  always_comb begin
    if (!pin_used) begin
      pin_nxt = 1'b0;
    end else if (is_pwm) begin
      pin_nxt = pwm_pin ^ output_invert_bit;
    end else begin
      pin_nxt = cmp_out_nxt ^ output_invert_bit;
    end
  end

  // ----------------------------------------------------------------
  // read data mux; low bytes come from the shared buffer
  // ----------------------------------------------------------------
  always_comb begin
    rdata_nxt = RST_BYTE;
    if (!reg_read) begin
      rdata_nxt = RST_BYTE;
    end else if (reg_addr == OFS_TIMER_CONTROL) begin
      rdata_nxt = {pause_r, 3'b000, timer_on_r, 3'b000};
    end else if (reg_addr == OFS_MODE_CONTROL) begin
      rdata_nxt = mode_control_r;
    end else if (reg_addr == OFS_COUNT_LOW) begin
      rdata_nxt = low_buf_r;
    end else if (reg_addr == OFS_COUNT_HIGH) begin
      rdata_nxt = count_r[15:8];
    end else if (reg_addr == OFS_MATCH_A_LOW) begin
      rdata_nxt = low_buf_r;
    end else if (reg_addr == OFS_MATCH_A_HIGH) begin
      rdata_nxt = compare_a_r[15:8];
    end else if (reg_addr == OFS_MATCH_P) begin
      rdata_nxt = compare_p_r;
    end else if (reg_addr == OFS_MATCH_FLAGS) begin
      rdata_nxt = {6'b00_0000, match_p_flag_r, match_a_flag_r};
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      timer_on_r     <= 1'b0;
      pause_r        <= 1'b0;
      mode_control_r <= RST_BYTE;
    end else begin
      if (wr_ctrl) begin
        timer_on_r <= reg_wdata[POS_TIMER_ON];
        pause_r    <= reg_wdata[POS_PAUSE];
      end
      if (wr_mode) begin
        mode_control_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // compare values and shared low-byte buffer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      compare_a_r <= RST_WORD;
      compare_p_r <= RST_BYTE;
      low_buf_r   <= RST_BYTE;
    end else begin
      if (wr_a_lo) low_buf_r <= reg_wdata;
      if (rd_c_hi) low_buf_r <= count_r[7:0];
      if (rd_a_hi) low_buf_r <= compare_a_r[7:0];
      if (wr_a_hi) compare_a_r <= {reg_wdata, low_buf_r};
      if (wr_p) compare_p_r <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // counter, output state and match flags
  // ----------------------------------------------------------------
  // flags clear by writing one; a match in the same cycle wins
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count_r        <= RST_WORD;
      cmp_out_r      <= 1'b0;
      match_a_flag_r <= 1'b0;
      match_p_flag_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      cmp_out_r <= cmp_out_nxt;
      if (a_hit) begin
        match_a_flag_r <= 1'b1;
      end else if (wr_flags & reg_wdata[POS_FLAG_A]) begin
        match_a_flag_r <= 1'b0;
      end
      if (p_hit & p_flags) begin
        match_p_flag_r <= 1'b1;
      end else if (wr_flags & reg_wdata[POS_FLAG_P]) begin
        match_p_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rdata_r  <= RST_BYTE;
      pin_r    <= 1'b0;
      pin_en_r <= 1'b0;
    end else begin
      rdata_r  <= rdata_nxt;
      pin_r    <= pin_nxt;
      pin_en_r <= pin_used;
    end
  end

  assign reg_rdata        = rdata_r;
  assign timer_output_pin = pin_r;
  assign timer_output_en  = pin_en_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_on_rise_zero;
    @(posedge clock) disable iff (!nrst)
    on_rise |=> (count_r == RST_WORD);
  endproperty
  a_on_rise_zero:
    assert property (p_on_rise_zero) else $error("counter not zeroed on start");

  property p_off_holds;
    @(posedge clock) disable iff (!nrst)
    (!timer_on_r && !on_rise) |=> (count_r == $past(count_r));
  endproperty
  a_off_holds:
    assert property (p_off_holds) else $error("counter moved while off");

  property p_step_incr;
    @(posedge clock) disable iff (!nrst)
    (step && !clr_hit) |=> (count_r == $past(count_r) + 16'h0001);
  endproperty
  a_step_incr:
    assert property (p_step_incr) else $error("counter missed a tick");

  property p_clear_a;
    @(posedge clock) disable iff (!nrst)
    (!is_pwm && clear_source_select && a_hit) |=> (count_r == RST_WORD);
  endproperty
  a_clear_a:
    assert property (p_clear_a) else $error("match A did not clear counter");

  property p_pwm_period;
    @(posedge clock) disable iff (!nrst)
    (is_pwm && !duty_period_swap && p_hit && !on_rise) |=> (count_r == RST_WORD);
  endproperty
  a_pwm_period:
    assert property (p_pwm_period) else $error("pwm period clear missed");

  property p_toggle;
    @(posedge clock) disable iff (!nrst)
    (is_cmp && a_hit && pin_function_select == PINF_TOGGLE)
      |=> (cmp_out_r != $past(cmp_out_r));
  endproperty
  a_toggle:
    assert property (p_toggle) else $error("toggle on match A missed");

  property p_start_level;
    @(posedge clock) disable iff (!nrst)
    on_rise |=> (cmp_out_r == $past(output_level_bit));
  endproperty
  a_start_level:
    assert property (p_start_level) else $error("initial level not restored");

  property p_timer_pin_off;
    @(posedge clock) disable iff (!nrst)
    (mode_select == MODE_TIMER) |=> !timer_output_en;
  endproperty
  a_timer_pin_off:
    assert property (p_timer_pin_off) else $error("pin driven in timer mode");

  property p_force_active;
    @(posedge clock) disable iff (!nrst)
    (is_pwm && pin_function_select == PWMF_ON)
      |=> (timer_output_pin == ($past(output_level_bit) ^ $past(output_invert_bit)));
  endproperty
  a_force_active:
    assert property (p_force_active) else $error("forced active level wrong");

  property p_a_high_latch;
    @(posedge clock) disable iff (!nrst)
    wr_a_hi |=> (compare_a_r == {$past(reg_wdata), $past(low_buf_r)});
  endproperty
  a_a_high_latch:
    assert property (p_a_high_latch) else $error("A value not latched from buffer");

  property p_count_read;
    @(posedge clock) disable iff (!nrst)
    rd_c_hi |=> (reg_rdata == $past(count_r[15:8])) && (low_buf_r == $past(count_r[7:0]));
  endproperty
  a_count_read:
    assert property (p_count_read) else $error("counter high read wrong");

endmodule : compact_timer

`default_nettype wire

// ===== test_compact_timer.sv
// Purpose: self-checking bench for the compact timer registers and output pin
// Assumes: a tick request keeps timer_tick high for one clock per counter step
// Notes:   bus tasks drop their strobe just after the taking edge, then settle
`timescale 1ns/1ps
`default_nettype none
module test_compact_timer
  import compact_timer_pkg::*;
;
  logic        clock = 1'b0;
  logic        nrst;
  logic        timer_tick;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_write;
  logic        reg_read;
  logic [7:0]  reg_rdata;
  logic        timer_output_pin;
  logic        timer_output_en;
  int          miscompares;
  int          cmp_count;
  int          cycles = 0;
  logic [7:0]  rv;
  logic [15:0] cv;
  logic        exp_pin;

  // ----------------------------------------------------------------
  // design and clock
  // ----------------------------------------------------------------
  compact_timer compact_timer_inst (
    .clock            (clock),
    .nrst             (nrst),
    .timer_tick       (timer_tick),
    .reg_addr         (reg_addr),
    .reg_wdata        (reg_wdata),
    .reg_write        (reg_write),
    .reg_read         (reg_read),
    .reg_rdata        (reg_rdata),
    .timer_output_pin (timer_output_pin),
    .timer_output_en  (timer_output_en)
  );

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // hang guard, well above the longest overflow run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 80000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  // high byte first so the low byte lands in the shared buffer
  task automatic rd_count(output logic [15:0] c);
    logic [7:0] h;
    logic [7:0] l;
    rd(OFS_COUNT_HIGH, h);
    rd(OFS_COUNT_LOW, l);
    c = {h, l};
  endtask : rd_count

  task automatic ticks(input int n);
    @(posedge clock);
    timer_tick <= 1'b1;
    repeat (n) @(posedge clock);
    timer_tick <= 1'b0;
    #1;
  endtask : ticks

  // switch off, change mode, switch on again
  task automatic restart(input logic [7:0] mode);
    wr(OFS_TIMER_CONTROL, 8'h00);
    wr(OFS_MODE_CONTROL, mode);
    wr(OFS_TIMER_CONTROL, 8'h08);
  endtask : restart

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst        = 1'b0;
    timer_tick  = 1'b0;
    reg_addr    = 4'h0;
    reg_wdata   = 8'h00;
    reg_write   = 1'b0;
    reg_read    = 1'b0;
    miscompares = 0;
    cmp_count   = 0;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    // reset values, one unmapped index included
    for (int a = 0; a < 9; a++) begin
      rd(a[3:0], rv);
      chk("reset value", {8'h00, rv}, 16'h0000);
    end
    wr(OFS_COUNT_LOW, 8'h5a);
    wr(OFS_COUNT_HIGH, 8'ha5);
    rd_count(cv);
    chk("count read only", cv, 16'h0000);
    wr(OFS_MODE_CONTROL, 8'h5a);
    rd(OFS_MODE_CONTROL, rv);
    chk("mode control", {8'h00, rv}, 16'h005a);
    // compare a through the shared buffer
    wr(OFS_MATCH_A_LOW, 8'h34);
    wr(OFS_MATCH_A_HIGH, 8'h12);
    rd(OFS_MATCH_A_HIGH, rv);
    chk("match a high", {8'h00, rv}, 16'h0012);
    rd(OFS_MATCH_A_LOW, rv);
    chk("match a low", {8'h00, rv}, 16'h0034);
    // counting, pause, off and on
    wr(OFS_MATCH_P, 8'h01);
    restart(8'h30);
    ticks(100);
    rd_count(cv);
    chk("count after ticks", cv, 16'h0064);
    wr(OFS_TIMER_CONTROL, 8'h88);
    ticks(7);
    rd_count(cv);
    chk("count paused", cv, 16'h0064);
    wr(OFS_TIMER_CONTROL, 8'h00);
    ticks(7);
    rd_count(cv);
    chk("count off", cv, 16'h0064);
    wr(OFS_TIMER_CONTROL, 8'h08);
    rd_count(cv);
    chk("count after on", cv, 16'h0000);
    // p match period of 256 ticks, pin left alone
    ticks(255);
    rd_count(cv);
    chk("count before p match", cv, 16'h00ff);
    ticks(1);
    rd_count(cv);
    chk("count after p match", cv, 16'h0000);
    rd(OFS_MATCH_FLAGS, rv);
    chk("p flag", {8'h00, rv}, 16'h0002);
    chk("pin after p match", {15'h0000, timer_output_pin}, 16'h0000);
    // zero p value wraps at the top of the count
    wr(OFS_MATCH_P, 8'h00);
    restart(8'h30);
    ticks(65535);
    rd_count(cv);
    chk("count at top", cv, 16'hffff);
    ticks(1);
    rd_count(cv);
    chk("count after overflow", cv, 16'h0000);
    // compare mode pin actions for every code, level and inversion
    wr(OFS_MATCH_A_LOW, 8'h04);
    wr(OFS_MATCH_A_HIGH, 8'h00);
    for (int pf = 0; pf < 4; pf++) begin
      for (int k = 0; k < 4; k++) begin
        restart({2'b00, pf[1:0], k[1], k[0], 2'b01});
        chk("pin at start", {15'h0000, timer_output_pin}, {15'h0000, k[1] ^ k[0]});
        chk("pin enabled", {15'h0000, timer_output_en}, 16'h0001);
        ticks(4);
        case (pf)
          0: exp_pin = k[1];
          1: exp_pin = 1'b0;
          2: exp_pin = 1'b1;
          default: exp_pin = ~k[1];
        endcase
        chk("pin after a match", {15'h0000, timer_output_pin}, {15'h0000, exp_pin ^ k[0]});
        rd_count(cv);
        chk("count cleared by a", cv, 16'h0000);
      end
    end
    restart(8'hc0);
    chk("pin released in timer mode", {15'h0000, timer_output_en}, 16'h0000);
    // pwm pin codes: period 256 from p, duty 64 from a
    wr(OFS_MATCH_A_LOW, 8'h40);
    wr(OFS_MATCH_A_HIGH, 8'h00);
    wr(OFS_MATCH_P, 8'h01);
    for (int pf = 0; pf < 3; pf++) begin
      for (int k = 0; k < 4; k++) begin
        restart({2'b10, pf[1:0], k[1], k[0], 2'b00});
        ticks(10);
        exp_pin = (pf == 0) ? ~k[1] : k[1];
        chk("pwm pin in duty", {15'h0000, timer_output_pin}, {15'h0000, exp_pin ^ k[0]});
        ticks(60);
        exp_pin = (pf == 1) ? k[1] : ~k[1];
        chk("pwm pin after duty", {15'h0000, timer_output_pin}, {15'h0000, exp_pin ^ k[0]});
      end
    end
    // clear source set in pwm must not shorten the period
    restart(8'ha9);
    ticks(356);
    rd_count(cv);
    chk("pwm period from p", cv, 16'h0064);
    // swapped roles: period 512 from a, duty 256 from p
    wr(OFS_MATCH_A_LOW, 8'h00);
    wr(OFS_MATCH_A_HIGH, 8'h02);
    restart(8'hab);
    ticks(300);
    chk("swapped pwm pin", {15'h0000, timer_output_pin}, 16'h0000);
    ticks(300);
    rd_count(cv);
    chk("swapped pwm period", cv, 16'h0058);
    print_verdict();
  end

endmodule : test_compact_timer
`default_nettype wire
